//--- design/diag_irq_pkg.sv
// Package with register layout, offsets and types of the diagnostic edge interrupt block
package diag_irq_pkg;

    localparam int          NUM_CH       = 4;
    localparam int          CH_WIDTH     = 8;
    localparam int          BUS_WIDTH    = 8;
    localparam int          NUM_BUSES    = 4;
    localparam int          ADDR_WIDTH   = 32;

    // Byte addresses, word aligned
    localparam logic [31:0] CTRL_ADDR    = 32'h4000_0204;
    localparam logic [31:0] STATUS_ADDR  = 32'h4000_0208;
    localparam logic [31:0] MASK_ADDR    = 32'h4000_020C;

    // Field positions within one channel byte
    localparam int          FLAG_POS     = 7;
    localparam int          POL_POS      = 6;
    localparam int          BITSEL_LO    = 3;
    localparam int          BUSSEL_LO    = 1;
    localparam int          IRQEN_POS    = 0;

    localparam logic [31:0] CTRL_RESET   = 32'h0000_0000;
    localparam logic [31:0] FLAG_BITS    = 32'h8080_8080;
    localparam logic [3:0]  CH_RESET     = 4'h0;

    localparam logic [1:0]  RESP_OKAY    = 2'h0;
    localparam logic [1:0]  RESP_SLVERR  = 2'h2;

    localparam logic [1:0]  BUS_LL0      = 2'h0;
    localparam logic [1:0]  BUS_LL1      = 2'h1;
    localparam logic [1:0]  BUS_RF0      = 2'h2;
    localparam logic [1:0]  BUS_RF1      = 2'h3;

    typedef struct packed {
        logic       trigPol;
        logic [2:0] bitPick;
        logic [1:0] busPick;
        logic       irqEnable;
    } ch_cfg_t;

    typedef struct packed {
        logic [7:0] rfProbe1;
        logic [7:0] rfProbe0;
        logic [7:0] llProbe1;
        logic [7:0] llProbe0;
    } probe_buses_t;

endpackage : diag_irq_pkg

//--- design/diag_edge_chan.sv
// One channel: bus and bit pick with edge detection
`timescale 1ns/10ps
module diag_edge_chan
(
    input  wire logic                   core_clk,  // System clock
    input  wire logic                   rst,       // Sync reset, high
    input  wire diag_irq_pkg::probe_buses_t probes, // All four probe buses
    input  wire diag_irq_pkg::ch_cfg_t  cfg,       // Channel configuration
    output logic                        edgeHit    // One-cycle edge pulse
);

    typedef struct packed {
        logic prevBit;
        logic primed;
    } chan_state_t;

    chan_state_t stateQ;
    chan_state_t stateD;
    logic [7:0]  busSel;
    logic        curBit;

    always_comb
    begin
        case (cfg.busPick)                                  // RULE8
            diag_irq_pkg::BUS_LL0: busSel = probes.llProbe0;
            diag_irq_pkg::BUS_LL1: busSel = probes.llProbe1;
            diag_irq_pkg::BUS_RF0: busSel = probes.rfProbe0;
            diag_irq_pkg::BUS_RF1: busSel = probes.rfProbe1;
            default:               busSel = probes.llProbe0;
        endcase
        curBit = busSel[cfg.bitPick];                       // RULE7
        stateD.prevBit = curBit;
        stateD.primed  = 1'b1;
        // Rising when polarity 0, falling when 1
        edgeHit = stateQ.primed && (curBit != stateQ.prevBit)
                  && (curBit == ~cfg.trigPol);              // RULE6
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            stateQ <= '0;
        end
        else
        begin
            stateQ <= stateD;
        end
    end

    chk_falling_edge_only: assert property (@(posedge core_clk) disable iff (rst) // RULE6
        (edgeHit && cfg.trigPol) |-> !curBit && $past(curBit))
        else $error("falling-edge hit without falling bit");

endmodule : diag_edge_chan

//--- design/diag_bus_edge_irq.sv
// Top of the four-channel diagnostic bus edge interrupt block with AXI4-Lite slave
//
// Overview of operation
// RULE1: Channel 0 fields sit in bits 7:0
// RULE2: Channels 1-3 repeat layout in upper bytes
// RULE3: Flag bits ignore software writes
// RULE4: Reading control register clears all flags; a channel whose edge comes in the read cycle keeps its flag set
// RULE5: Chosen edge sets sticky flag until read
// RULE6: Polarity 0 rising, 1 falling edge
// RULE7: Bit pick chooses one of eight bits
// RULE8: Bus pick chooses one of four buses
// RULE9: Enabled channel interrupts on each flag rise; diag_irq_out also needs the channel's evMask bit, which resets to 0
//
// Implementation choice: the AXI4-Lite slave port.
`timescale 1ns/10ps
module diag_bus_edge_irq
(
    input  wire logic        core_clk,            // System clock, 100 MHz
    input  wire logic        rst,                 // Sync reset, high
    input  wire logic [7:0]  link_layer_probe_bus_0, // Link-layer probe bus 0
    input  wire logic [7:0]  link_layer_probe_bus_1, // Link-layer probe bus 1
    input  wire logic [7:0]  rf_probe_bus_0,      // Radio probe bus 0
    input  wire logic [7:0]  rf_probe_bus_1,      // Radio probe bus 1
    output logic             diag_irq_out,        // Interrupt level
    input  wire logic [31:0] s_axi_awaddr,        // Write address
    input  wire logic [2:0]  s_axi_awprot,        // Write protection, unused
    input  wire logic        s_axi_awvalid,       // Write address valid
    output logic             s_axi_awready,       // Write address ready
    input  wire logic [31:0] s_axi_wdata,         // Write data
    input  wire logic [3:0]  s_axi_wstrb,         // Write byte enables
    input  wire logic        s_axi_wvalid,        // Write data valid
    output logic             s_axi_wready,        // Write data ready
    output logic [1:0]       s_axi_bresp,         // Write response
    output logic             s_axi_bvalid,        // Write response valid
    input  wire logic        s_axi_bready,        // Write response ready
    input  wire logic [31:0] s_axi_araddr,        // Read address
    input  wire logic [2:0]  s_axi_arprot,        // Read protection, unused
    input  wire logic        s_axi_arvalid,       // Read address valid
    output logic             s_axi_arready,       // Read address ready
    output logic [31:0]      s_axi_rdata,         // Read data
    output logic [1:0]       s_axi_rresp,         // Read response
    output logic             s_axi_rvalid,        // Read data valid
    input  wire logic        s_axi_rready         // Read data ready
);

    localparam int NCH = diag_irq_pkg::NUM_CH;
    localparam int CW  = diag_irq_pkg::CH_WIDTH;

    typedef struct packed {
        logic [31:0] ctrl;       // Config bits; flag bit positions held zero
        logic [3:0]  flag;       // Event flags
        logic [3:0]  evSticky;   // Interrupt status, write one to clear
        logic [3:0]  evMask;     // Interrupt status mask
        logic        awHeld;
        logic [31:0] awAddr;
        logic        wHeld;
        logic [31:0] wData;
        logic [3:0]  wStrb;
        logic        bValid;
        logic [1:0]  bResp;
        logic        rValid;
        logic [1:0]  rResp;
        logic [31:0] rData;
        logic        irq;
    } top_state_t;

    top_state_t stateQ;
    top_state_t stateD;

    diag_irq_pkg::probe_buses_t probes;
    diag_irq_pkg::ch_cfg_t      cfg [NCH];
    logic [NCH-1:0]             edgeHit;
    logic [NCH-1:0]             flagRise;
    logic [31:0]                readWord;
    logic                       doWrite;
    logic                       doRead;
    logic                       rdCtrl;
    logic [31:0]                wrMask;

    assign probes.llProbe0 = link_layer_probe_bus_0;
    assign probes.llProbe1 = link_layer_probe_bus_1;
    assign probes.rfProbe0 = rf_probe_bus_0;
    assign probes.rfProbe1 = rf_probe_bus_1;

    // ========================================================================
    // Channels
    // ========================================================================
    genvar gi;
    generate
        for (gi = 0; gi < NCH; gi++)
        begin : g_ch
            // Same field layout in each byte
            assign cfg[gi].trigPol   = stateQ.ctrl[gi*CW + diag_irq_pkg::POL_POS];  // RULE2
            assign cfg[gi].bitPick   = stateQ.ctrl[gi*CW + diag_irq_pkg::BITSEL_LO +: 3];
            assign cfg[gi].busPick   = stateQ.ctrl[gi*CW + diag_irq_pkg::BUSSEL_LO +: 2];
            assign cfg[gi].irqEnable = stateQ.ctrl[gi*CW + diag_irq_pkg::IRQEN_POS];

            diag_edge_chan u_chan
            (
                .core_clk (core_clk),
                .rst      (rst),
                .probes   (probes),
                .cfg      (cfg[gi]),
                .edgeHit  (edgeHit[gi])
            );

            assign flagRise[gi] = edgeHit[gi] && !stateQ.flag[gi];

            // Control word with live flags at bit 7 of each byte
            always_comb
            begin
                readWord[gi*CW +: CW] = stateQ.ctrl[gi*CW +: CW];
                readWord[gi*CW + diag_irq_pkg::FLAG_POS] = stateQ.flag[gi];  // RULE1
            end
        end
    endgenerate

    // ========================================================================
    // Bus handshake
    // ========================================================================
    assign s_axi_awready = !stateQ.awHeld;
    assign s_axi_wready  = !stateQ.wHeld;
    assign s_axi_arready = !stateQ.rValid;
    assign s_axi_bvalid  = stateQ.bValid;
    assign s_axi_bresp   = stateQ.bResp;
    assign s_axi_rvalid  = stateQ.rValid;
    assign s_axi_rresp   = stateQ.rResp;
    assign s_axi_rdata   = stateQ.rData;
    assign diag_irq_out  = stateQ.irq;

    assign doWrite = stateQ.awHeld && stateQ.wHeld && !stateQ.bValid;
    assign doRead  = s_axi_arvalid && !stateQ.rValid;
    assign rdCtrl  = doRead && (s_axi_araddr == diag_irq_pkg::CTRL_ADDR);

    always_comb
    begin
        for (int b = 0; b < 4; b++)
        begin
            wrMask[b*8 +: 8] = {8{stateQ.wStrb[b]}};
        end
    end

    // ========================================================================
    // Next state
    // ========================================================================
    always_comb
    begin
        stateD = stateQ;

        if (s_axi_awvalid && !stateQ.awHeld)
        begin
            stateD.awHeld = 1'b1;
            stateD.awAddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !stateQ.wHeld)
        begin
            stateD.wHeld = 1'b1;
            stateD.wData = s_axi_wdata;
            stateD.wStrb = s_axi_wstrb;
        end
        if (stateQ.bValid && s_axi_bready)
        begin
            stateD.bValid = 1'b0;
        end
        if (stateQ.rValid && s_axi_rready)
        begin
            stateD.rValid = 1'b0;
        end

        // Register writes
        if (doWrite)
        begin
            stateD.awHeld = 1'b0;
            stateD.wHeld  = 1'b0;
            stateD.bValid = 1'b1;
            stateD.bResp  = diag_irq_pkg::RESP_OKAY;
            case (stateQ.awAddr)
                diag_irq_pkg::CTRL_ADDR:
                    // Flag positions stay zero in ctrl
                    stateD.ctrl = ((stateQ.ctrl & ~wrMask) | (stateQ.wData & wrMask))
                                  & ~diag_irq_pkg::FLAG_BITS;                       // RULE3
                diag_irq_pkg::STATUS_ADDR:
                    stateD.evSticky = stateQ.evSticky
                                      & ~(stateQ.wData[3:0] & {4{stateQ.wStrb[0]}});
                diag_irq_pkg::MASK_ADDR:
                    if (stateQ.wStrb[0])
                    begin
                        stateD.evMask = stateQ.wData[3:0];
                    end
                default:
                    stateD.bResp = diag_irq_pkg::RESP_SLVERR;
            endcase
        end

        // Register reads
        if (doRead)
        begin
            stateD.rValid = 1'b1;
            stateD.rResp  = diag_irq_pkg::RESP_OKAY;
            case (s_axi_araddr)
                diag_irq_pkg::CTRL_ADDR:   stateD.rData = readWord;
                diag_irq_pkg::STATUS_ADDR: stateD.rData = {28'h000_0000, stateQ.evSticky};
                diag_irq_pkg::MASK_ADDR:   stateD.rData = {28'h000_0000, stateQ.evMask};
                default:
                begin
                    stateD.rData = 32'h0000_0000;
                    stateD.rResp = diag_irq_pkg::RESP_SLVERR;
                end
            endcase
        end

        // Flags: read clears, a new edge in the same cycle wins
        for (int c = 0; c < NCH; c++)
        begin
            if (rdCtrl)
            begin
                stateD.flag[c] = 1'b0;                                  // RULE4
            end
            if (edgeHit[c])
            begin
                stateD.flag[c] = 1'b1;                                  // RULE5
            end
            // Enabled flag rise marks the interrupt status
            if (flagRise[c] && cfg[c].irqEnable)
            begin
                stateD.evSticky[c] = 1'b1;                              // RULE9
            end
        end

        stateD.irq = |(stateD.evSticky & stateD.evMask);
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            stateQ        <= '0;
            stateQ.ctrl   <= diag_irq_pkg::CTRL_RESET;
            stateQ.evMask <= diag_irq_pkg::CH_RESET;
        end
        else
        begin
            stateQ <= stateD;
        end
    end

    // ========================================================================
    // Checks
    // ========================================================================
    chk_flag_sets_edge: assert property (@(posedge core_clk) disable iff (rst) // RULE5
        edgeHit[0] |=> stateQ.flag[0])
        else $error("edge did not set channel 0 flag");

    chk_read_clears_flag: assert property (@(posedge core_clk) disable iff (rst) // RULE4
        (rdCtrl && !edgeHit[1]) |=> !stateQ.flag[1])
        else $error("read did not clear channel 1 flag");

    chk_flag_write_ro: assert property (@(posedge core_clk) disable iff (rst) // RULE3
        (stateQ.ctrl & diag_irq_pkg::FLAG_BITS) == 32'h0000_0000)
        else $error("flag bit stored in control word");

    chk_read_flag_pos: assert property (@(posedge core_clk) disable iff (rst) // RULE1
        rdCtrl |=> s_axi_rdata[diag_irq_pkg::FLAG_POS] == $past(stateQ.flag[0]))
        else $error("channel 0 flag not at bit 7");

    chk_ch3_layout: assert property (@(posedge core_clk) disable iff (rst) // RULE2
        cfg[3].busPick == stateQ.ctrl[26:25] && cfg[3].bitPick == stateQ.ctrl[29:27])
        else $error("channel 3 fields misplaced");

    chk_irq_on_rise: assert property (@(posedge core_clk) disable iff (rst) // RULE9
        (flagRise[2] && cfg[2].irqEnable && stateQ.evMask[2]) |=> diag_irq_out)
        else $error("enabled flag rise gave no interrupt");

    chk_irq_disabled: assert property (@(posedge core_clk) disable iff (rst) // RULE9
        (!cfg[3].irqEnable && flagRise[3]) |=> $stable(stateQ.evSticky[3]) || !stateQ.evSticky[3])
        else $error("disabled channel raised status");

    chk_bus_select: assert property (@(posedge core_clk) disable iff (rst) // RULE8
        (cfg[3].busPick == diag_irq_pkg::BUS_RF1 && cfg[3].trigPol == 1'b1
         && $fell(rf_probe_bus_1[cfg[3].bitPick]) && $stable(cfg[3])) |-> edgeHit[3])
        else $error("radio bus 1 fall not detected");

    chk_bit_select: assert property (@(posedge core_clk) disable iff (rst) // RULE7
        (cfg[0].busPick == diag_irq_pkg::BUS_LL0 && $stable(cfg[0])
         && $stable(link_layer_probe_bus_0[cfg[0].bitPick])) |-> !edgeHit[0])
        else $error("edge from unselected bit");

endmodule : diag_bus_edge_irq

//--- tb/diag_probe_model.sv
// Far-side model: link-layer and radio logic that drives the four probe buses
`timescale 1ns/10ps
module diag_probe_model
(
    input  wire logic                       core_clk, // System clock
    input  wire diag_irq_pkg::probe_buses_t levelsIn, // Levels for the next cycle
    output logic [7:0]                      llBus0,   // Link-layer probe bus 0
    output logic [7:0]                      llBus1,   // Link-layer probe bus 1
    output logic [7:0]                      rfBus0,   // Radio probe bus 0
    output logic [7:0]                      rfBus1    // Radio probe bus 1
);
    // ==========================================================
    // Registered levels, as core logic would present them
    diag_irq_pkg::probe_buses_t levels_q;

    always_ff @(posedge core_clk)
        levels_q <= levelsIn;

    assign llBus0 = levels_q.llProbe0;
    assign llBus1 = levels_q.llProbe1;
    assign rfBus0 = levels_q.rfProbe0;
    assign rfBus1 = levels_q.rfProbe1;
endmodule : diag_probe_model

//--- tb/diag_bus_edge_irq_tb.sv
// Self-checking testbench for the diagnostic bus edge interrupt block
`timescale 1ns/10ps
module diag_bus_edge_irq_tb;
    logic core_clk, rst, diag_irq_out;
    logic [7:0] ll0, ll1, rf0, rf1;
    diag_irq_pkg::probe_buses_t levels;
    logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    logic [31:0] cfg, rd;
    int n_errors, checks;

    diag_probe_model far (.core_clk(core_clk), .levelsIn(levels), .llBus0(ll0), .llBus1(ll1),
        .rfBus0(rf0), .rfBus1(rf1));
    diag_bus_edge_irq dut (.core_clk(core_clk), .rst(rst), .link_layer_probe_bus_0(ll0),
        .link_layer_probe_bus_1(ll1), .rf_probe_bus_0(rf0), .rf_probe_bus_1(rf1),
        .diag_irq_out(diag_irq_out), .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'h0),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arprot(3'h0),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready));

    // ==========================================================
    // Bus tasks and comparison
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("ERROR at %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic axi_write(input logic [31:0] a, input logic [31:0] d);
        bit aw, w;
        int n;
        aw = 0; w = 0; n = 0;
        s_axi_awaddr <= a; s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1; s_axi_wvalid <= 1'b1; s_axi_bready <= 1'b1;
        while (!(aw && w) && n < 50)
        begin
            @(posedge core_clk); n++;
            if (!aw && s_axi_awready) begin aw = 1; s_axi_awvalid <= 1'b0; end
            if (!w && s_axi_wready) begin w = 1; s_axi_wvalid <= 1'b0; end
        end
        do begin @(posedge core_clk); n++; end while (s_axi_bvalid !== 1'b1 && n < 50);
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
        @(posedge core_clk);
        if (n >= 50) chk(32'h1, 32'h0);
    endtask : axi_write

    task automatic axi_read(input logic [31:0] a);
        int n;
        n = 0;
        s_axi_araddr <= a; s_axi_arvalid <= 1'b1; s_axi_rready <= 1'b1;
        do begin @(posedge core_clk); n++; end while (s_axi_arready !== 1'b1 && n < 50);
        s_axi_arvalid <= 1'b0;
        do begin @(posedge core_clk); n++; end while (s_axi_rvalid !== 1'b1 && n < 50);
        rd = s_axi_rdata; resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
        @(posedge core_clk);
        if (n >= 50) chk(32'h1, 32'h0);
    endtask : axi_read

    // ==========================================================
    // Scenarios
    task automatic test_reset_map;
        axi_read(diag_irq_pkg::CTRL_ADDR);
        chk(rd, diag_irq_pkg::CTRL_RESET);
        axi_read(32'h4000_0300);
        chk({30'h0, resp}, {30'h0, diag_irq_pkg::RESP_SLVERR});
        axi_write(32'h4000_0300, 32'h0);
        chk({30'h0, resp}, {30'h0, diag_irq_pkg::RESP_SLVERR});
    endtask : test_reset_map

    task automatic test_edges;
        logic [2:0] b;
        cfg = 32'h0;
        for (int c = 0; c < 4; c++)
        begin
            b = 3'(2 * c + 1);
            cfg[c*8 +: 8] = {1'b0, c[0], b, c[1:0], c != 3};
            levels[c*8 + b] <= c[0];
        end
        repeat (3) @(posedge core_clk);
        axi_write(diag_irq_pkg::CTRL_ADDR, cfg);
        chk({30'h0, resp}, {30'h0, diag_irq_pkg::RESP_OKAY});
        axi_read(diag_irq_pkg::CTRL_ADDR);
        chk(rd, cfg);
        for (int c = 0; c < 4; c++)
            levels[c*8 + 2*c + 1] <= !c[0];
        repeat (4) @(posedge core_clk);
        axi_read(diag_irq_pkg::CTRL_ADDR);
        chk(rd, cfg | diag_irq_pkg::FLAG_BITS);
        axi_read(diag_irq_pkg::CTRL_ADDR);
        chk(rd, cfg);
    endtask : test_edges

    task automatic test_irq;
        axi_read(diag_irq_pkg::STATUS_ADDR);
        chk(rd, 32'h7);
        chk({31'h0, diag_irq_out}, 32'h0);
        axi_write(diag_irq_pkg::MASK_ADDR, 32'hF);
        repeat (2) @(posedge core_clk);
        chk({31'h0, diag_irq_out}, 32'h1);
        axi_write(diag_irq_pkg::STATUS_ADDR, 32'hF);
        repeat (2) @(posedge core_clk);
        chk({31'h0, diag_irq_out}, 32'h0);
        axi_read(diag_irq_pkg::STATUS_ADDR);
        chk(rd, 32'h0);
        levels.rfProbe0[5] <= 1'b0;
        repeat (2) @(posedge core_clk);
        levels.rfProbe0[5] <= 1'b1;
        repeat (4) @(posedge core_clk);
        chk({31'h0, diag_irq_out}, 32'h1);
        axi_read(diag_irq_pkg::STATUS_ADDR);
        chk(rd, 32'h4);
        axi_read(diag_irq_pkg::CTRL_ADDR);
        chk(rd, cfg | 32'h0080_0000);
        axi_write(diag_irq_pkg::STATUS_ADDR, 32'h4);
        chk({31'h0, diag_irq_out}, 32'h0);
    endtask : test_irq

    task automatic test_back_edge_ro;
        for (int c = 0; c < 4; c++)
            levels[c*8 + 2*c + 1] <= c[0];
        levels.llProbe0[5] <= 1'b1;
        repeat (4) @(posedge core_clk);
        axi_read(diag_irq_pkg::CTRL_ADDR);
        chk(rd, cfg);
        axi_write(diag_irq_pkg::CTRL_ADDR, cfg | diag_irq_pkg::FLAG_BITS);
        axi_read(diag_irq_pkg::CTRL_ADDR);
        chk(rd, cfg);
    endtask : test_back_edge_ro

    // ==========================================================
    // Verdict
    task automatic final_report;
        $display("Comparisons %0d, mismatches %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : final_report

    initial
    begin
        core_clk = 0;
        forever #5 core_clk = ~core_clk;
    end

    initial
    begin
        #200000;
        n_errors++;
        final_report();
    end

    initial
    begin
        rst = 1; levels = '0; s_axi_awaddr = 0; s_axi_wdata = 0; s_axi_araddr = 0;
        s_axi_awvalid = 0; s_axi_wvalid = 0; s_axi_bready = 0;
        s_axi_arvalid = 0; s_axi_rready = 0;
        n_errors = 0; checks = 0;
        repeat (6) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        test_reset_map();
        test_edges();
        test_irq();
        test_back_edge_ro();
        final_report();
    end
endmodule : diag_bus_edge_irq_tb
